// ===== rtl/edg_top.sv
// Error diffusion grayscale pixel pipeline with an AHB-Lite register slave.
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`include "edg_defs.svh"

module edg_top #(
   parameter int PIX_W = `EDG_IN_BITS
) (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic [1:0]        mode_select,
   input  wire logic              bypass,
   input  wire logic              low_power_n,
   input  wire logic              clock_out_phase_select,
   input  wire edg_pkg::edg_pix_t red_in,
   input  wire edg_pkg::edg_pix_t green_in,
   input  wire edg_pkg::edg_pix_t blue_in,
   input  wire logic              line_sync_in,
   input  wire logic              frame_sync_in,
   input  wire logic              line_valid_in,
   input  wire logic              panel_ctrl_in,
   output logic      [3:0]        red_out,
   output logic      [3:0]        green_out,
   output logic      [3:0]        blue_out,
   output logic                   line_sync_out,
   output logic                   frame_sync_out,
   output logic                   line_valid_out,
   output logic                   panel_ctrl_out,
   output logic                   dot_clock_out,
   output logic                   dot_clock_out_inverted
);

   typedef struct packed {
      logic [1:0]        mode_s1;
      logic [1:0]        mode_s2;
      logic              byp_s1;
      logic              byp_s2;
      logic              lpn_s1;
      logic              lpn_s2;
      logic              sel_s1;
      logic              sel_s2;
      edg_pkg::edg_pix_t cap_r;
      edg_pkg::edg_pix_t cap_g;
      edg_pkg::edg_pix_t cap_b;
      logic              cap_hs;
      logic              cap_vs;
      logic              cap_de;
      logic              cap_ctl;
      logic              prev_hs;
      logic              prev_vs;
      logic              pix_par;
      logic              line_par;
      logic              frame_par;
      logic [15:0]       pix_cnt;
      logic [15:0]       line_cnt;
      logic [15:0]       line_pixels;
      logic [15:0]       frame_lines;
      logic [15:0]       frame_cnt;
      logic              soft_bypass;
      logic              no_inter;
      logic              dp_write;
      logic [11:0]       dp_addr;
      logic [31:0]       hrdata;
      logic [3:0]        red_out;
      logic [3:0]        green_out;
      logic [3:0]        blue_out;
      logic              line_sync_out;
      logic              frame_sync_out;
      logic              line_valid_out;
      logic              panel_ctrl_out;
      logic              clk_sel;
   } edg_top_state_t;

   edg_top_state_t      st;
   edg_top_state_t      next_st;
   edg_pkg::edg_mode_t  mode;
   logic                run;
   logic                wide;
   logic                inter;
   logic                byp_act;
   logic                phase;
   logic                line_start;
   logic                frame_start;
   logic                accept;
   logic [11:0]         acc_addr;
   logic [31:0]         rd_word;
   edg_pkg::edg_pix_t   cap_pix [3];
   logic [11:0]         chan_res;
   logic [11:0]         chan_dly;
   logic [3:0]          ctl_dly;

   initial
   begin
      if (PIX_W != `EDG_IN_BITS)
         $error("edg_top serves eight-bit colour samples only.");
   end

   // The straps are quasi-static pins, so each passes two flip-flops first; the clock phase select passes three.
   assign mode        = edg_pkg::edg_mode_t'(st.mode_s2);
   assign run         = st.lpn_s2;
   assign wide        = (mode != edg_pkg::EDG_MODE_3BIT);
   // Reserved code 3 falls back to the intra-frame only behaviour.
   assign inter       = (mode == edg_pkg::EDG_MODE_3BIT || mode == edg_pkg::EDG_MODE_4BIT)
                        && !st.no_inter;
   assign byp_act     = st.byp_s2 | st.soft_bypass;
   assign phase       = st.pix_par ^ st.line_par ^ st.frame_par;
   assign line_start  = st.prev_hs && !st.cap_hs;
   assign frame_start = st.prev_vs && !st.cap_vs;
   assign accept      = hsel && htrans[1] && hready;
   assign acc_addr    = haddr[11:0] & `EDG_ADDR_MASK;

   assign cap_pix[0] = st.cap_r;
   assign cap_pix[1] = st.cap_g;
   assign cap_pix[2] = st.cap_b;

   genvar c;
   generate
      for (c = 0; c < 3; c++)
      begin : g_chan
         edg_diffuse u_dif (
            .mclk       (mclk),
            .rst_n      (rst_n),
            .run        (run),
            .pix        (cap_pix[c]),
            .pix_valid  (st.cap_de),
            .line_clear (!st.cap_hs),
            .wide       (wide),
            .inter      (inter),
            .phase      (phase),
            .bypass     (byp_act),
            .result     (chan_res[4*c+3:4*c])
         );
      end
   endgenerate

   // Capture, diffuse, three stages of delay, then the output flop: six clocks.
   edg_delay #(
      .W     (12),
      .DEPTH (`EDG_PIPE_LAT - 2)
   ) u_dly_pix (
      .mclk  (mclk),
      .rst_n (rst_n),
      .din   (chan_res),
      .dout  (chan_dly)
   );

   edg_delay #(
      .W     (4),
      .DEPTH (`EDG_PIPE_LAT - 1)
   ) u_dly_ctl (
      .mclk  (mclk),
      .rst_n (rst_n),
      .din   ({st.cap_hs, st.cap_vs, st.cap_de, st.cap_ctl}),
      .dout  (ctl_dly)
   );

   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (acc_addr)
         `EDG_ADDR_CTRL:
            rd_word = {30'h0, st.no_inter, st.soft_bypass};
         `EDG_ADDR_STATUS:
            rd_word = {27'h0, st.frame_par, byp_act, !run, st.mode_s2};
         `EDG_ADDR_FRAME_COUNT:
            rd_word = {16'h0, st.frame_cnt};
         `EDG_ADDR_LINE_PIXELS:
            rd_word = {16'h0, st.line_pixels};
         `EDG_ADDR_FRAME_LINES:
            rd_word = {16'h0, st.frame_lines};
         default:
            rd_word = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      next_st = st;
      next_st.mode_s1 = mode_select;
      next_st.mode_s2 = st.mode_s1;
      next_st.byp_s1  = bypass;
      next_st.byp_s2  = st.byp_s1;
      next_st.lpn_s1  = low_power_n;
      next_st.lpn_s2  = st.lpn_s1;
      next_st.sel_s1  = clock_out_phase_select;
      next_st.sel_s2  = st.sel_s1;
      next_st.clk_sel = st.sel_s2;

      next_st.cap_r   = red_in;
      next_st.cap_g   = green_in;
      next_st.cap_b   = blue_in;
      next_st.cap_hs  = line_sync_in;
      next_st.cap_vs  = frame_sync_in;
      next_st.cap_de  = line_valid_in;
      next_st.cap_ctl = panel_ctrl_in;

      // Sync edge tracking and counters freeze while processing is stopped.
      if (run)
      begin
         next_st.prev_hs = st.cap_hs;
         next_st.prev_vs = st.cap_vs;
         if (st.cap_de)
         begin
            next_st.pix_cnt = st.pix_cnt + 16'h0001;
            next_st.pix_par = !st.pix_par;
         end
         if (line_start)
         begin
            next_st.line_pixels = st.pix_cnt;
            next_st.pix_cnt     = `EDG_CNT_RESET;
            next_st.pix_par     = 1'b0;
            next_st.line_cnt    = st.line_cnt + 16'h0001;
            next_st.line_par    = !st.line_par;
         end
         if (frame_start)
         begin
            next_st.frame_lines = st.line_cnt;
            next_st.line_cnt    = `EDG_CNT_RESET;
            next_st.line_par    = 1'b0;
            next_st.frame_cnt   = st.frame_cnt + 16'h0001;
            next_st.frame_par   = !st.frame_par;
         end
      end

      if (run)
      begin
         next_st.red_out        = chan_dly[3:0];
         next_st.green_out      = chan_dly[7:4];
         next_st.blue_out       = chan_dly[11:8];
         next_st.line_sync_out  = ctl_dly[3];
         next_st.frame_sync_out = ctl_dly[2];
         next_st.line_valid_out = ctl_dly[1];
         next_st.panel_ctrl_out = ctl_dly[0];
      end
      else
      begin
         // Outputs must come from flops, so the pass-through costs one capture stage.
         next_st.red_out        = 4'hf;
         next_st.green_out      = 4'hf;
         next_st.blue_out       = 4'hf;
         next_st.line_sync_out  = line_sync_in;
         next_st.frame_sync_out = frame_sync_in;
         next_st.line_valid_out = line_valid_in;
         next_st.panel_ctrl_out = panel_ctrl_in;
      end

      next_st.dp_write = accept && hwrite;
      next_st.dp_addr  = acc_addr;
      if (accept && !hwrite)
         next_st.hrdata = rd_word;
      if (st.dp_write && st.dp_addr == `EDG_ADDR_CTRL)
      begin
         next_st.soft_bypass = hwdata[`EDG_CTRL_BYPASS_BIT];
         next_st.no_inter    = hwdata[`EDG_CTRL_NOINTER_BIT];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         st             <= '0;
         st.lpn_s1      <= `EDG_STRAP_LPN_RESET;
         st.lpn_s2      <= `EDG_STRAP_LPN_RESET;
         st.cap_hs      <= 1'b1;
         st.cap_vs      <= 1'b1;
         st.prev_hs     <= 1'b1;
         st.prev_vs     <= 1'b1;
         st.soft_bypass <= 1'(`EDG_CTRL_RESET >> `EDG_CTRL_BYPASS_BIT);
         st.no_inter    <= 1'(`EDG_CTRL_RESET >> `EDG_CTRL_NOINTER_BIT);
      end
      else
      begin
         st <= next_st;
      end
   end

   assign hrdata         = st.hrdata;
   assign hreadyout      = rst_n | 1'b1;
   assign hresp          = 1'b0;
   assign red_out        = st.red_out;
   assign green_out      = st.green_out;
   assign blue_out       = st.blue_out;
   assign line_sync_out  = st.line_sync_out;
   assign frame_sync_out = st.frame_sync_out;
   assign line_valid_out = st.line_valid_out;
   assign panel_ctrl_out = st.panel_ctrl_out;

   // The clock outputs are gated copies of mclk; a flop could not follow both edges.
   assign dot_clock_out          = mclk & st.clk_sel;
   assign dot_clock_out_inverted = ~mclk & ~st.clk_sel;

endmodule : edg_top

// ===== rtl/edg_defs.svh
// Offsets, field positions, reset values and timing counts of the error diffusion block.
`ifndef EDG_DEFS_SVH
`define EDG_DEFS_SVH

`define EDG_IN_BITS            8
`define EDG_OUT_BITS           4
`define EDG_PIPE_LAT           5
`define EDG_ADDR_MASK          12'hffc
`define EDG_ADDR_CTRL          12'h000
`define EDG_ADDR_STATUS        12'h004
`define EDG_ADDR_FRAME_COUNT   12'h008
`define EDG_ADDR_LINE_PIXELS   12'h00c
`define EDG_ADDR_FRAME_LINES   12'h010
`define EDG_CTRL_BYPASS_BIT    0
`define EDG_CTRL_NOINTER_BIT   1
`define EDG_CTRL_RESET         2'h0
`define EDG_STAT_MODE_LSB      0
`define EDG_STAT_SAVE_BIT      2
`define EDG_STAT_BYPASS_BIT    3
`define EDG_STAT_FPAR_BIT      4
`define EDG_CNT_RESET          16'h0000
`define EDG_STRAP_LPN_RESET    1'h1

`endif

// ===== rtl/edg_pkg.sv
// Types shared by the error diffusion block.
package edg_pkg;

   typedef enum logic [1:0] {
      EDG_MODE_3BIT,
      EDG_MODE_4BIT,
      EDG_MODE_INTRA,
      EDG_MODE_RSVD
   } edg_mode_t;

   typedef logic [7:0] edg_pix_t;

endpackage : edg_pkg

// ===== rtl/edg_delay.sv
// Fixed-depth delay line used to align data and sync with the output stage.
module edg_delay #(
   parameter int W     = 4,
   parameter int DEPTH = 4
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] stage;
   } edg_dly_state_t;

   edg_dly_state_t st;
   edg_dly_state_t next_st;

   initial
   begin
      if (DEPTH < 1 || W < 1)
         $error("edg_delay needs a positive width and depth.");
   end

   always_comb
   begin
      next_st = st;
      next_st.stage[0] = din;
      for (int i = 1; i < DEPTH; i++)
         next_st.stage[i] = st.stage[i-1];
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign dout = st.stage[DEPTH-1];

endmodule : edg_delay

// ===== rtl/edg_diffuse.sv
// One colour channel: quantiser with horizontal error carry and temporal offset.
module edg_diffuse (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              run,
   input  wire edg_pkg::edg_pix_t pix,
   input  wire logic              pix_valid,
   input  wire logic              line_clear,
   input  wire logic              wide,
   input  wire logic              inter,
   input  wire logic              phase,
   input  wire logic              bypass,
   output logic            [3:0]  result
);

   typedef struct packed {
      logic signed [9:0] err;
      logic        [3:0] result;
   } edg_dif_state_t;

   edg_dif_state_t st;
   edg_dif_state_t next_st;
   logic signed [10:0] toff;
   logic signed [10:0] v;
   logic        [7:0]  vc;
   logic        [3:0]  q4;
   logic        [2:0]  q3;
   logic        [7:0]  recon;
   logic signed [9:0]  e;

   always_comb
   begin
      next_st = st;
      // Temporal offset alternates sign per pixel, line and frame so that a level
      // between two output steps is shown as a blend over successive frames.
      if (!inter)
         toff = 11'sh000;
      else if (phase)
         toff = wide ? 11'sh004 : 11'sh008;
      else
         toff = wide ? -11'sh004 : -11'sh008;
      v = $signed({3'h0, pix}) + $signed({st.err[9], st.err}) + toff;
      if (v < 11'sh000)
         vc = 8'h00;
      else if (v > 11'sh0ff)
         vc = 8'hff;
      else
         vc = v[7:0];
      q4 = vc[7:4];
      q3 = vc[7:5];
      // Bit replication maps the top code to full scale, so white carries no error.
      recon = wide ? {q4, q4} : {q3, q3, q3[2:1]};
      e = $signed({2'h0, vc}) - $signed({2'h0, recon});
      if (line_clear)
         next_st.err = 10'sh000;
      else if (run && pix_valid && !bypass)
         next_st.err = e;
      if (run)
      begin
         if (bypass)
            next_st.result = wide ? pix[7:4] : {pix[7:5], 1'b0};
         else
            next_st.result = wide ? q4 : {q3, 1'b0};
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign result = st.result;

endmodule : edg_diffuse

// ===== tb/edg_checker.sv
// Checker for delays, power save, mode and bypass behaviour of the pixel pipeline.
module edg_checker (
   input wire logic              mclk,
   input wire logic              rst_n,
   input wire logic [1:0]        mode_select,
   input wire logic              bypass,
   input wire logic              low_power_n,
   input wire edg_pkg::edg_pix_t red_in,
   input wire logic              line_sync_in,
   input wire logic              frame_sync_in,
   input wire logic              line_valid_in,
   input wire logic              panel_ctrl_in,
   input wire logic [3:0]        red_out,
   input wire logic [3:0]        green_out,
   input wire logic [3:0]        blue_out,
   input wire logic              line_sync_out,
   input wire logic              frame_sync_out,
   input wire logic              line_valid_out,
   input wire logic              panel_ctrl_out
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // Inputs pass two sync flops, so each check except a_save_enter waits until its condition has stood 15 cycles.
   logic [3:0] run_cnt;
   logic [3:0] save_cnt;
   logic [3:0] byp_cnt;
   logic [3:0] mode_cnt;
   logic [1:0] mode_q;
   always_ff @(posedge mclk)
   begin
      run_cnt  <= (!rst_n || !low_power_n) ? 4'h0 : run_cnt + 4'(run_cnt != 4'hf);
      save_cnt <= (!rst_n || low_power_n) ? 4'h0 : save_cnt + 4'(save_cnt != 4'hf);
      byp_cnt  <= (!rst_n || !bypass) ? 4'h0 : byp_cnt + 4'(byp_cnt != 4'hf);
      mode_cnt <= (!rst_n || mode_select != mode_q) ? 4'h0 : mode_cnt + 4'(mode_cnt != 4'hf);
      mode_q   <= mode_select;
   end
   a_line_delay: assert property (run_cnt == 4'hf |-> line_sync_out == $past(line_sync_in, 6))
      else $error("line sync lag wrong");
   a_frame_delay: assert property (run_cnt == 4'hf |-> frame_sync_out == $past(frame_sync_in, 6))
      else $error("frame sync lag wrong");
   a_valid_delay: assert property ($rose(line_valid_in) ##6 run_cnt == 4'hf |-> $rose(line_valid_out))
      else $error("line valid lag wrong");
   a_ctrl_delay: assert property (run_cnt == 4'hf |-> panel_ctrl_out == $past(panel_ctrl_in, 6))
      else $error("panel control lag wrong");
   a_save_enter: assert property ($fell(low_power_n) |-> ##[2:6] {red_out, green_out, blue_out} == 12'hfff)
      else $error("power save not entered");
   a_save_high: assert property (save_cnt == 4'hf |-> {red_out, green_out, blue_out} == 12'hfff)
      else $error("colours not high in power save");
   a_save_pass: assert property (save_cnt == 4'hf |-> {line_sync_out, frame_sync_out, line_valid_out,
      panel_ctrl_out} == $past({line_sync_in, frame_sync_in, line_valid_in, panel_ctrl_in}))
      else $error("power save pass-through wrong");
   a_mode0_lsb: assert property (mode_cnt == 4'hf && run_cnt == 4'hf && mode_select == 2'h0
      |-> !(red_out[0] | green_out[0] | blue_out[0]))
      else $error("low bit set in three-bit mode");
   a_bypass_msb: assert property (byp_cnt == 4'hf && run_cnt == 4'hf && mode_select != 2'h0
      |-> red_out == $past(red_in[7:4], 6))
      else $error("bypass data wrong");
   cover property (save_cnt == 4'hf);
   cover property (byp_cnt == 4'hf && run_cnt == 4'hf && mode_select == 2'h1);
   cover property (mode_cnt == 4'hf && run_cnt == 4'hf && mode_select == 2'h0);
endmodule : edg_checker

bind edg_top edg_checker i_edg_checker (.mclk, .rst_n, .mode_select, .bypass, .low_power_n,
   .red_in, .line_sync_in, .frame_sync_in, .line_valid_in, .panel_ctrl_in, .red_out, .green_out,
   .blue_out, .line_sync_out, .frame_sync_out, .line_valid_out, .panel_ctrl_out);

// ===== tb/edg_gfx_model.sv
// Behavioural display controller: raster timing, syncs and pixel data.
module edg_gfx_model #(
   parameter int ACTIVE = 16,
   parameter int LINES  = 4
) (
   input  wire logic              mclk,
   input  wire logic              run,
   input  wire logic              ramp,
   input  wire edg_pkg::edg_pix_t pix,
   output edg_pkg::edg_pix_t      red_in,
   output edg_pkg::edg_pix_t      green_in,
   output edg_pkg::edg_pix_t      blue_in,
   output logic                   line_sync_in,
   output logic                   frame_sync_in,
   output logic                   line_valid_in,
   output logic                   panel_ctrl_in
);
   int x = 0;
   int y = 0;
   always @(posedge mclk)
   begin
      x <= (!run || x == ACTIVE + 5) ? 0 : x + 1;
      if (!run)
         y <= 0;
      else if (x == ACTIVE + 5)
         y <= (y == LINES - 1) ? 0 : y + 1;
   end
   always_comb
   begin
      line_sync_in  = !(run && x < 2);
      frame_sync_in = !(run && y == 0 && x < 2);
      line_valid_in = run && x >= 4 && x < ACTIVE + 4;
      panel_ctrl_in = run && y[0];
      // Blanking data changes every cycle, so a stale sample never looks right.
      red_in   = line_valid_in ? pix ^ (ramp ? 8'(x * 13) : 8'h00) : 8'(x * 37 + 5);
      green_in = line_valid_in ? pix : 8'(x * 37 + 5);
      blue_in  = line_valid_in ? pix : 8'(x * 37 + 5);
   end
endmodule : edg_gfx_model

// ===== tb/tb_error_diffusion_grayscale.sv
// Self-checking bench of the pixel pipeline against a behavioural display controller.
`include "edg_defs.svh"
module tb_error_diffusion_grayscale;
   timeunit 1ns;
   timeprecision 100ps;
   logic              mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rd2;
   logic [1:0]        htrans = 2'h0, mode_select = 2'h2;
   logic [2:0]        hsize = 3'h2;
   logic              bypass = 1'b0, low_power_n = 1'b1, clock_out_phase_select = 1'b1;
   logic              run = 1'b0, ramp = 1'b0, hreadyout, hresp;
   edg_pkg::edg_pix_t pix = 8'h00, red_in, green_in, blue_in;
   logic              line_sync_in, frame_sync_in, line_valid_in, panel_ctrl_in;
   logic [3:0]        red_out, green_out, blue_out, ln [16], ln2 [16];
   logic              line_sync_out, frame_sync_out, line_valid_out, panel_ctrl_out;
   logic              dot_clock_out, dot_clock_out_inverted;
   int                err_count = 0;
   int                comparisons = 0;

   always #2.5 mclk = ~mclk;

   edg_top i_edg_top (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mode_select, .bypass, .low_power_n,
      .clock_out_phase_select, .red_in, .green_in, .blue_in, .line_sync_in, .frame_sync_in,
      .line_valid_in, .panel_ctrl_in, .red_out, .green_out, .blue_out, .line_sync_out,
      .frame_sync_out, .line_valid_out, .panel_ctrl_out, .dot_clock_out, .dot_clock_out_inverted);
   edg_gfx_model i_edg_gfx_model (.mclk, .run, .ramp, .pix, .red_in, .green_in, .blue_in,
      .line_sync_in, .frame_sync_in, .line_valid_in, .panel_ctrl_in);

   task automatic report_and_stop;
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic give_up;
      err_count++;
      report_and_stop();
   endtask : give_up

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
      begin
         if (++n > 50)
            give_up();
         @(posedge mclk);
      end
   endtask : wait_ready

   // One single-word transfer; the address phase is held until the slave is ready.
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {20'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      d = hrdata;
   endtask : ahb

   // Records the red output over the next whole output line.
   task automatic grab(output logic [3:0] v [16]);
      logic p;
      int   n;
      p = 1'b1;
      n = 0;
      forever
      begin
         @(posedge mclk);
         #1;
         if (line_valid_out === 1'b1 && p === 1'b0)
            break;
         p = line_valid_out;
         if (++n > 200)
            give_up();
      end
      foreach (v[i])
      begin
         v[i] = red_out;
         @(posedge mclk);
         #1;
      end
   endtask : grab

   initial
   begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      ahb(1'b0, `EDG_ADDR_CTRL, 32'h0, rd);
      check(rd, 32'h0);
      check({31'h0, hresp}, 32'h0);
      ahb(1'b1, `EDG_ADDR_CTRL, 32'hffffffff, rd);
      ahb(1'b0, `EDG_ADDR_CTRL, 32'h0, rd);
      check(rd, 32'h3);
      ahb(1'b1, 12'h020, 32'h1, rd);
      ahb(1'b0, 12'h020, 32'h0, rd);
      check(rd, 32'h0);
      ahb(1'b1, `EDG_ADDR_CTRL, 32'h0, rd);
      run <= 1'b1;
      // The reserved mode code is never driven.
      for (int m = 0; m < 3; m++)
         for (int v = 0; v < 2; v++)
         begin
            mode_select <= 2'(m);
            pix         <= v ? 8'hff : 8'h00;
            repeat (60) @(posedge mclk);
            ahb(1'b0, `EDG_ADDR_STATUS, 32'h0, rd);
            check({30'h0, rd[1:0]}, 32'(m));
            grab(ln);
            foreach (ln[i])
               check(32'(ln[i]), v == 0 ? 32'h0 : m == 0 ? 32'he : 32'hf);
         end
      pix <= 8'h3c;
      repeat (60) @(posedge mclk);
      grab(ln);
      grab(ln2);
      rd2 = 32'h0;
      foreach (ln[i])
      begin
         check(32'(ln[i] == 4'h3 || ln[i] == 4'h4), 32'h1);
         check(32'(ln2[i]), 32'(ln[i]));
         rd2 = rd2 | (32'h1 << ln[i]);
      end
      check(rd2, 32'h18);
      // The two samples lie exactly two frames apart, so the phase of the raster cannot matter.
      ahb(1'b0, `EDG_ADDR_FRAME_COUNT, 32'h0, rd);
      repeat (174) @(posedge mclk);
      ahb(1'b0, `EDG_ADDR_FRAME_COUNT, 32'h0, rd2);
      check({16'h0, rd2[15:0] - rd[15:0]}, 32'h2);
      ahb(1'b0, `EDG_ADDR_LINE_PIXELS, 32'h0, rd);
      check(rd, 32'h10);
      ahb(1'b0, `EDG_ADDR_FRAME_LINES, 32'h0, rd);
      check(rd, 32'h3);
      ramp <= 1'b1;
      pix  <= 8'h5a;
      // First pass uses the pin in mode 1, second the soft control bit in mode 2.
      for (int s = 0; s < 2; s++)
      begin
         bypass      <= !s;
         mode_select <= s ? 2'h2 : 2'h1;
         ahb(1'b1, `EDG_ADDR_CTRL, 32'(s), rd);
         repeat (40) @(posedge mclk);
         grab(ln);
         foreach (ln[i])
            check(32'(ln[i]), 32'((8'h5a ^ 8'((i + 4) * 13)) >> 4));
         ahb(1'b0, `EDG_ADDR_STATUS, 32'h0, rd);
         check({31'h0, rd[`EDG_STAT_BYPASS_BIT]}, 32'h1);
      end
      ahb(1'b1, `EDG_ADDR_CTRL, 32'h0, rd);
      ramp        <= 1'b0;
      low_power_n <= 1'b0;
      repeat (10) @(posedge mclk);
      ahb(1'b0, `EDG_ADDR_STATUS, 32'h0, rd);
      check({31'h0, rd[`EDG_STAT_SAVE_BIT]}, 32'h1);
      ahb(1'b0, `EDG_ADDR_FRAME_COUNT, 32'h0, rd);
      repeat (176) @(posedge mclk);
      ahb(1'b0, `EDG_ADDR_FRAME_COUNT, 32'h0, rd2);
      check(rd2, rd);
      check({20'h0, red_out, green_out, blue_out}, 32'hfff);
      low_power_n <= 1'b1;
      for (int s = 1; s >= 0; s--)
      begin
         clock_out_phase_select <= 1'(s);
         repeat (8) @(posedge mclk);
         #1;
         check({30'h0, dot_clock_out, dot_clock_out_inverted}, {30'h0, 1'(s), 1'b0});
         @(negedge mclk);
         #1;
         check({30'h0, dot_clock_out, dot_clock_out_inverted}, {30'h0, 1'b0, !1'(s)});
         @(posedge mclk);
      end
      ahb(1'b1, `EDG_ADDR_CTRL, 32'h2, rd);
      rst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      ahb(1'b0, `EDG_ADDR_CTRL, 32'h0, rd);
      check(rd, 32'h0);
      report_and_stop();
   end
endmodule : tb_error_diffusion_grayscale
